// file: flash_program_erase_control.sv
// flash program/erase control: mode register, block select, unit buffer and array
// assumes a single ahb-lite master; the protect pin is asynchronous to mclk
module flash_program_erase_control #(
   parameter int ARRAY_WORDS = flash_pec_pkg::ARRAY_WORDS
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic hw_program_permit_n,
   output logic [6:0] mode_bits,
   output logic erase_busy,
   output logic program_busy
);
   import flash_pec_pkg::*;

   typedef struct packed {
      logic [6:0] ctl;
      logic [NUM_BLOCKS-1:0] blk_sel;
      seq_state_e st;
      logic [3:0] blk;
      logic [WORD_AW-1:0] waddr;
      logic [WORD_AW-1:0] wend;
      logic [9:0] unit;
      logic [UNIT_WORDS-1:0][31:0] pbuf;
      logic [WORD_AW-1:0] a_addr;
      logic a_arr;
      logic a_reg;
      logic a_wr;
      logic a_rd;
      logic [31:0] hrdata;
      logic hreadyout;
      logic erase_busy;
      logic program_busy;
   } ctrl_s;

   ctrl_s s;
   ctrl_s next_s;

   logic pin_level;
   logic permit;
   logic take;
   logic ok_set;
   logic erase_write;
   logic program_write;
   logic [WORD_AW-1:0] program_addr;
   logic [WORD_AW-1:0] span_first;
   logic [WORD_AW-1:0] span_last;
   logic span_valid;
   logic [31:0] mem [0:ARRAY_WORDS-1];
   logic [31:0] mem_q;

   // the protect pin is a raw pad level, so it is synchronised first
   pin_sync #(
      .WIDTH(1),
      .RESET_VAL(PROTECT_PIN_RESET)
   ) u_pin_sync (
      .mclk(mclk),
      .reset_n(reset_n),
      .async_in(hw_program_permit_n),
      .sync_out(pin_level)
   );

   // low pin level grants permission
   assign permit = ~pin_level;

   // bounds of the block the erase walk is looking at
   block_span u_block_span (
      .blk(s.blk),
      .first_word(span_first),
      .last_word(span_last),
      .valid(span_valid)
   );

   // an address phase is taken only when the bus is ready and active
   assign take = hsel & htrans[1] & hready;

   // array writes happen only in a live sequence with the pin still permitting
   assign erase_write = (s.st == st_erase) & permit & s.ctl[BIT_ERASE_GO];
   assign program_write = (s.st == st_program) & permit & s.ctl[BIT_PROGRAM_GO];
   assign program_addr = {s.unit, s.waddr[4:0]};

   // array storage; no reset, contents are whatever the last erase or program left
   always_ff @(posedge mclk) begin
      if (erase_write) begin
         mem[s.waddr] <= ERASED_WORD;
      end else if (program_write) begin
         // bits can only go from one to zero, unerased data is merged not replaced
         mem[program_addr] <= mem[program_addr] & s.pbuf[s.waddr[4:0]];
      end
      if (take) begin
         mem_q <= mem[haddr[16:2]];
      end
   end

   // bus slave, mode register and sequencer
   always_comb begin
      next_s = s;
      ok_set = permit & s.ctl[BIT_SOFT_PERMIT];

      // read data phase: one wait state so a preceding register write is always seen
      if (s.a_rd) begin
         next_s.a_rd = 1'b0;
         next_s.hreadyout = 1'b1;
         next_s.hrdata = 32'h0000_0000;
         if (s.a_arr) begin
            next_s.hrdata = mem_q;
         end else if (s.a_reg) begin
            case (s.a_addr[1:0])
               IDX_MODE_CTL_ONE: next_s.hrdata = {24'h00_0000, permit, s.ctl};
               IDX_BLOCK_SELECT: next_s.hrdata = {22'h00_0000, s.blk_sel};
               IDX_STATUS: next_s.hrdata = {29'h0000_0000, permit, s.program_busy, s.erase_busy};
               default: next_s.hrdata = 32'h0000_0000;
            endcase
         end
      end

      // write data phase
      if (s.a_wr) begin
         next_s.a_wr = 1'b0;
         if (s.a_reg && s.a_addr[1:0] == IDX_MODE_CTL_ONE) begin
            // each bit takes a 1 only if its condition holds before this write
            next_s.ctl[BIT_SOFT_PERMIT] = permit & hwdata[BIT_SOFT_PERMIT];
            next_s.ctl[BIT_ERASE_SETUP] = ok_set & hwdata[BIT_ERASE_SETUP];
            next_s.ctl[BIT_PROGRAM_SETUP] = ok_set & hwdata[BIT_PROGRAM_SETUP];
            next_s.ctl[BIT_ERASE_VERIFY] = ok_set & hwdata[BIT_ERASE_VERIFY];
            next_s.ctl[BIT_PROGRAM_VERIFY] = ok_set & hwdata[BIT_PROGRAM_VERIFY];
            next_s.ctl[BIT_ERASE_GO] = ok_set & s.ctl[BIT_ERASE_SETUP]
               & hwdata[BIT_ERASE_GO];
            next_s.ctl[BIT_PROGRAM_GO] = ok_set & s.ctl[BIT_PROGRAM_SETUP]
               & hwdata[BIT_PROGRAM_GO];
            // dropping the soft permit takes every other bit down with it
            if (!next_s.ctl[BIT_SOFT_PERMIT]) begin
               next_s.ctl = MODE_CTL_RESET;
               next_s.blk_sel = BLOCK_SELECT_RESET;
            end
         end else if (s.a_reg && s.a_addr[1:0] == IDX_BLOCK_SELECT) begin
            next_s.blk_sel = hwdata[NUM_BLOCKS-1:0] & {NUM_BLOCKS{ok_set}};
         end else if (s.a_arr && s.ctl[BIT_SOFT_PERMIT] && s.st == st_idle) begin
            // array writes only fill the unit buffer; the array moves on program go
            next_s.unit = s.a_addr[14:5];
            next_s.pbuf[s.a_addr[4:0]] = hwdata;
         end
      end

      // address phase
      if (take) begin
         next_s.a_addr = haddr[16:2];
         next_s.a_arr = (haddr <= OFF_ARRAY_TOP);
         next_s.a_reg = (haddr[31:4] == OFF_MODE_CTL_ONE[31:4]);
         if (hwrite) begin
            next_s.a_wr = 1'b1;
         end else begin
            next_s.a_rd = 1'b1;
            next_s.hreadyout = 1'b0;
         end
      end

      // losing the pin permission clears the whole mode state at once
      if (!permit) begin
         next_s.ctl = MODE_CTL_RESET;
         next_s.blk_sel = BLOCK_SELECT_RESET;
      end

      // sequencer walk
      case (s.st)
         st_idle: begin
            next_s.st = st_idle;
         end
         st_seek: begin
            if (!span_valid) begin
               next_s.st = st_idle;
               next_s.erase_busy = 1'b0;
            end else if (s.blk_sel[s.blk]) begin
               next_s.waddr = span_first;
               next_s.wend = span_last;
               next_s.st = st_erase;
            end else begin
               next_s.blk = s.blk + 4'h1;
            end
         end
         st_erase: begin
            if (s.waddr == s.wend) begin
               next_s.blk = s.blk + 4'h1;
               next_s.st = st_seek;
            end else begin
               next_s.waddr = s.waddr + 15'h0001;
            end
         end
         st_program: begin
            if (s.waddr[4:0] == 5'(UNIT_WORDS - 1)) begin
               next_s.st = st_idle;
               next_s.program_busy = 1'b0;
               // buffer returns to all ones so untouched words leave cells alone
               next_s.pbuf = {UNIT_WORDS{ERASED_WORD}};
            end else begin
               next_s.waddr = s.waddr + 15'h0001;
            end
         end
         default: begin
            next_s.st = st_idle;
            next_s.erase_busy = 1'b0;
            next_s.program_busy = 1'b0;
         end
      endcase

      // clearing a go bit, by software or by the pin, ends its mode at once
      if ((s.st == st_seek || s.st == st_erase) && !next_s.ctl[BIT_ERASE_GO]) begin
         next_s.st = st_idle;
         next_s.erase_busy = 1'b0;
      end
      if (s.st == st_program && !next_s.ctl[BIT_PROGRAM_GO]) begin
         next_s.st = st_idle;
         next_s.program_busy = 1'b0;
      end

      // a go bit just accepted while idle starts its walk; erase wins if both rise at once
      if (s.st == st_idle) begin
         if (next_s.ctl[BIT_ERASE_GO] && !s.ctl[BIT_ERASE_GO]) begin
            next_s.st = st_seek;
            next_s.blk = 4'h0;
            next_s.erase_busy = 1'b1;
         end else if (next_s.ctl[BIT_PROGRAM_GO] && !s.ctl[BIT_PROGRAM_GO]) begin
            next_s.st = st_program;
            next_s.waddr = 15'h0000;
            next_s.program_busy = 1'b1;
         end
      end
   end

   // one register stage for all control state
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         s.ctl <= MODE_CTL_RESET;
         s.blk_sel <= BLOCK_SELECT_RESET;
         s.st <= st_idle;
         s.blk <= 4'h0;
         s.waddr <= 15'h0000;
         s.wend <= 15'h0000;
         s.unit <= 10'h000;
         s.pbuf <= {UNIT_WORDS{ERASED_WORD}};
         s.a_addr <= 15'h0000;
         s.a_arr <= 1'b0;
         s.a_reg <= 1'b0;
         s.a_wr <= 1'b0;
         s.a_rd <= 1'b0;
         s.hrdata <= 32'h0000_0000;
         s.hreadyout <= 1'b1;
         s.erase_busy <= 1'b0;
         s.program_busy <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   // every answer is okay, so the response line never moves
   assign hresp = 1'b0;
   assign hreadyout = s.hreadyout;
   assign hrdata = s.hrdata;
   assign mode_bits = s.ctl;
   assign erase_busy = s.erase_busy;
   assign program_busy = s.program_busy;
endmodule // flash_program_erase_control

// file: flash_pec_pkg.sv
// constants, field layout and types shared by the flash program/erase control
// assumes a 128-kbyte array seen as 32-bit words, registers above it on the bus
package flash_pec_pkg;

   // array geometry
   localparam int ARRAY_BYTES = 131072;
   localparam int ARRAY_WORDS = ARRAY_BYTES / 4;
   localparam int WORD_AW = 15;
   localparam int UNIT_BYTES = 128;
   localparam int UNIT_WORDS = UNIT_BYTES / 4;
   localparam int NUM_BLOCKS = 10;
   localparam logic [31:0] ERASED_WORD = 32'hffff_ffff;

   // erase block byte bases, entry NUM_BLOCKS is the end of the array
   localparam logic [NUM_BLOCKS:0][16:0] BLOCK_BASE = {
      17'h2_0000, 17'h1_8000, 17'h1_0000, 17'h0_e000, 17'h0_c000, 17'h0_8000,
      17'h0_1000, 17'h0_0c00, 17'h0_0800, 17'h0_0400, 17'h0_0000};

   // bus map: array at the bottom, registers in the window above it
   localparam logic [31:0] OFF_ARRAY_TOP = 32'h0001_ffff;
   localparam logic [31:0] OFF_MODE_CTL_ONE = 32'h0002_0000;
   localparam logic [31:0] OFF_BLOCK_SELECT = 32'h0002_0004;
   localparam logic [31:0] OFF_STATUS = 32'h0002_0008;
   localparam logic [1:0] IDX_MODE_CTL_ONE = OFF_MODE_CTL_ONE[3:2];
   localparam logic [1:0] IDX_BLOCK_SELECT = OFF_BLOCK_SELECT[3:2];
   localparam logic [1:0] IDX_STATUS = OFF_STATUS[3:2];

   // flash_mode_control_one bit positions
   localparam int BIT_HW_PERMIT = 7;
   localparam int BIT_SOFT_PERMIT = 6;
   localparam int BIT_ERASE_SETUP = 5;
   localparam int BIT_PROGRAM_SETUP = 4;
   localparam int BIT_ERASE_VERIFY = 3;
   localparam int BIT_PROGRAM_VERIFY = 2;
   localparam int BIT_ERASE_GO = 1;
   localparam int BIT_PROGRAM_GO = 0;

   // status register bit positions
   localparam int STAT_ERASE_BUSY = 0;
   localparam int STAT_PROGRAM_BUSY = 1;
   localparam int STAT_HW_PERMIT = 2;

   // values after reset
   localparam logic [6:0] MODE_CTL_RESET = 7'h00;
   localparam logic [NUM_BLOCKS-1:0] BLOCK_SELECT_RESET = 10'h000;
   localparam logic PROTECT_PIN_RESET = 1'b1;

   typedef enum logic [3:0] {
      st_idle = 4'h1,
      st_seek = 4'h2,
      st_erase = 4'h4,
      st_program = 4'h8
   } seq_state_e;

endpackage

// file: pin_sync.sv
// two-flop synchroniser for a level coming from a pin
// assumes the pin is slow against mclk; only the second flop is read
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic RESET_VAL = 1'b1
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_s;

   sync_s s;
   sync_s next_s;

   // meta feeds stable only
   always_comb begin
      next_s.meta = async_in;
      next_s.stable = s.meta;
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         s <= {(2 * WIDTH){RESET_VAL}};
      end else begin
         s <= next_s;
      end
   end

   assign sync_out = s.stable;
endmodule // pin_sync

// file: block_span.sv
// erase block lookup: first and last word address of one erase block
// assumes block numbers count from the bottom of the array upward
module block_span (
   input wire logic [3:0] blk,
   output logic [flash_pec_pkg::WORD_AW-1:0] first_word,
   output logic [flash_pec_pkg::WORD_AW-1:0] last_word,
   output logic valid
);
   import flash_pec_pkg::*;

   logic [3:0] idx;
   logic [16:0] next_base;

   // out-of-range numbers map to block 0 but are flagged invalid
   always_comb begin
      valid = (blk < 4'(NUM_BLOCKS));
      idx = valid ? blk : 4'h0;
      next_base = BLOCK_BASE[idx + 4'h1];
      first_word = BLOCK_BASE[idx][16:2];
      last_word = next_base[16:2] - 15'h0001;
   end
endmodule // block_span

// file: flash_pec_asserts.sv
// checker for the flash program/erase control: control bits and walk flags
// assumes it is bound to the top module and sees only its ports
module flash_pec_checker (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic hw_program_permit_n,
   input wire logic [6:0] mode_bits,
   input wire logic erase_busy,
   input wire logic program_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   // pin high long enough to pass the two-flop synchroniser
   sequence pin_off_s;
      hw_program_permit_n [*5];
   endsequence
   sequence erase_go_s;
      $rose(mode_bits[1]);
   endsequence
   sequence erase_run_s;
      ##[0:1] erase_busy;
   endsequence

   // each set of a gated bit needs its enables already in place
   pin_blocks_all_a: assert property (pin_off_s |-> mode_bits == 7'h00 && !erase_busy && !program_busy)
      else $error("flash work allowed without pin permit");
   soft_clears_all_a: assert property ($fell(mode_bits[6]) |-> mode_bits[5:0] == 6'h00)
      else $error("control bits survive soft permit clear");
   erase_setup_gate_a: assert property ($rose(mode_bits[5]) |-> $past(mode_bits[6]))
      else $error("erase setup set without soft permit");
   program_setup_gate_a: assert property ($rose(mode_bits[4]) |-> $past(mode_bits[6]))
      else $error("program setup set without soft permit");
   verify_gate_a: assert property ($rose(mode_bits[3]) || $rose(mode_bits[2]) |-> $past(mode_bits[6]))
      else $error("verify bit set without soft permit");
   erase_go_gate_a: assert property (erase_go_s |-> $past(mode_bits[5]) && $past(mode_bits[6]))
      else $error("erase go set without erase setup");
   erase_start_a: assert property (erase_go_s |-> erase_run_s)
      else $error("erase walk did not start");
   erase_abort_a: assert property (!mode_bits[1] [*2] |-> !erase_busy)
      else $error("erase walk runs without go bit");
   program_go_gate_a: assert property ($rose(mode_bits[0]) |-> $past(mode_bits[4]))
      else $error("program go set without program setup");
endmodule // flash_pec_checker

bind flash_program_erase_control flash_pec_checker i_chk (.mclk(mclk), .reset_n(reset_n),
   .hw_program_permit_n(hw_program_permit_n), .mode_bits(mode_bits), .erase_busy(erase_busy),
   .program_busy(program_busy));

// file: tb_top.sv
// self-checking bench for the flash program/erase control over ahb-lite
// assumes a single bus slave, so hready is the design's own hreadyout
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import flash_pec_pkg::*;
   logic mclk = 1'h0, reset_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, hw_program_permit_n = 1'h1, perm = 1'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hready, hreadyout, hresp, erase_busy, program_busy;
   logic [6:0] mode_bits, mexp = 7'h00;
   logic [31:0] pdat [2][32];
   int fail_count = 0, checks_done = 0, cyc = 0;

   assign hready = hreadyout;
   flash_program_erase_control i_dut (.mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .hw_program_permit_n(hw_program_permit_n),
      .mode_bits(mode_bits), .erase_busy(erase_busy), .program_busy(program_busy));

   // 10 mhz clock
   initial forever #50 mclk = ~mclk;

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // hang guard, well above the two erase walks
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fail_count = fail_count + 1;
         finish_test();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // looks at hready on the falling edge, so the rising edge that samples it is never raced
   task automatic wait_rdy(output logic [31:0] d);
      int n;
      n = 0;
      do begin @(negedge mclk); n++; end while (hreadyout !== 1'h1 && n < 50);
      d = hrdata;
      @(posedge mclk);
   endtask

   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] d);
      hsel <= 1'h1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      wait_rdy(d);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy(d);
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
      bus(1'h0, a, 32'h0, rd);
      check(rd, e);
      check({31'h0, hresp}, 32'h0); // okay response on every read
   endtask

   // setting conditions use the bits as they stood before the write
   function automatic logic [6:0] next_mode(logic [6:0] m, logic [6:0] w, logic p);
      logic [6:0] r;
      r = w & {p, {4{p & m[6]}}, p & m[6] & m[5], p & m[6] & m[4]};
      return r[6] ? r : 7'h00;
   endfunction

   task automatic mode_wr(input logic [7:0] w);
      bus(1'h1, OFF_MODE_CTL_ONE, {24'h0, w}, rd);
      mexp = next_mode(mexp, w[6:0], perm);
      bus(1'h0, OFF_MODE_CTL_ONE, 32'h0, rd);
      check(rd, {24'h0, perm, mexp});
      check({25'h0, mode_bits}, {25'h0, mexp});
   endtask

   task automatic pin(input logic v);
      hw_program_permit_n <= v;
      repeat (6) @(posedge mclk);
      perm = !v;
      if (v) mexp = 7'h00;
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      do begin @(negedge mclk); n++; end while ((erase_busy | program_busy) !== 1'h0 && n < 9000);
      @(posedge mclk);
   endtask

   task automatic erase(input logic [9:0] sel);
      bus(1'h1, OFF_BLOCK_SELECT, {22'h0, sel}, rd);
      mode_wr(8'h60);
      mode_wr(8'h62);
      rd_chk(OFF_STATUS, 32'h5);
      wait_idle();
      mode_wr(8'h40);
   endtask

   task automatic prog(input logic [31:0] base, input int k);
      for (int i = 0; i < UNIT_WORDS; i++) begin
         pdat[k][i] = $urandom;
         bus(1'h1, base + 4 * i, pdat[k][i], rd);
      end
      mode_wr(8'h50);
      mode_wr(8'h51);
      rd_chk(OFF_STATUS, 32'h6);
      wait_idle();
      mode_wr(8'h40);
   endtask

   // k of 2 means the unit should read erased
   task automatic unit_chk(input logic [31:0] base, input int k);
      for (int i = 0; i < UNIT_WORDS; i++) begin
         bus(1'h0, base + 4 * i, 32'h0, rd);
         check(rd, (k > 1) ? ERASED_WORD : pdat[k][i]);
      end
   endtask

   // main sequence
   initial begin
      void'($urandom(32'h6d16));
      repeat (16) @(posedge mclk);
      reset_n <= 1'h1;
      @(posedge mclk);
      rd_chk(OFF_MODE_CTL_ONE, 32'h0);
      rd_chk(OFF_BLOCK_SELECT, 32'h0);
      rd_chk(OFF_STATUS, 32'h0);
      rd_chk(32'h0002_000c, 32'h0);
      mode_wr(8'hff);
      $display("test reset done");
      pin(1'h0);
      rd_chk(OFF_STATUS, 32'h4);
      mode_wr(8'h20);
      mode_wr(8'h40);
      for (int b = 2; b < 6; b++) mode_wr(8'h40 | (8'h01 << b));
      mode_wr(8'h42);
      mode_wr(8'h7c);
      mode_wr(8'h3c);
      repeat (24) mode_wr(8'($urandom) & 8'hfe);
      $display("test mode register done");
      mode_wr(8'h40);
      bus(1'h1, OFF_BLOCK_SELECT, 32'h3ff, rd);
      rd_chk(OFF_BLOCK_SELECT, 32'h3ff);
      erase(10'h018);
      unit_chk(32'h0000_0c00, 2);
      unit_chk(32'h0000_7f80, 2);
      repeat (8) rd_chk(32'h1000 + ((32'($urandom) % 32'h7000) & 32'hffff_fffc), ERASED_WORD);
      rd_chk(OFF_STATUS, 32'h4);
      prog(32'h0000_0f80, 0);
      prog(32'h0000_1000, 1);
      unit_chk(32'h0000_0f80, 0);
      unit_chk(32'h0000_1000, 1);
      erase(10'h010);
      unit_chk(32'h0000_0f80, 0);
      unit_chk(32'h0000_1000, 2);
      $display("test erase and program done");
      mode_wr(8'h60);
      pin(1'h1);
      rd_chk(OFF_MODE_CTL_ONE, 32'h0);
      rd_chk(OFF_BLOCK_SELECT, 32'h0);
      mode_wr(8'h40);
      $display("test pin loss done");
      finish_test();
   end
endmodule // tb_top
